// [hdl/nbu_pkg.sv]
// Notes on behaviour
// - frame: start, eight data LSB first, ninth, stop
// - buffer write loads ninth bit, requests send
// - transmit starts after next divide-by-16 rollover
// - start bit, then data, then shifting
// - first shift inserts stop, then zeros
// - final shift ends send, sets tx done
// - receive pin sampled at sixteen times baud
// - falling edge resets counter, loads 1F
// - majority vote of samples seven, eight, nine
// - nonzero start bit rejects false start
// - nine-bit shift register, start reaching left ends; code ends on a shift count of nine
// - load only if done clear and ninth allowed
// - failed conditions discard frame, no done flag
// - load ninth flag, data byte, set done
// - one bit time later resume edge hunt
// - stop bit value affects no result
// - channel baud clock source selectable
// - fixed rate variant divides oscillator by 32/64
package nbu_pkg;
  // -------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------
  localparam logic [11:0] BUF_OFF  = 12'h000;
  localparam logic [11:0] CTRL_OFF = 12'h004;
  localparam logic [11:0] BAUD_OFF = 12'h008;
  // control bits
  localparam int C_TX9  = 0;
  localparam int C_RX9  = 1;
  localparam int C_TXD  = 2;
  localparam int C_RXD  = 3;
  localparam int C_MPE  = 4;
  localparam int C_SRC  = 5;
  localparam int C_FIX  = 6;
  localparam int C_F64  = 7;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [15:0] BAUD_RST  = 16'h0000;
  localparam logic [8:0]  RX_INIT   = 9'h01F;
  localparam logic [3:0]  SAMP_A    = 4'h6;
  localparam logic [3:0]  SAMP_C    = 4'h8;
  localparam logic [5:0]  FIX32_DIV = 6'h01;
  localparam logic [5:0]  FIX64_DIV = 6'h03;
  localparam logic [3:0]  TX_BITS   = 4'hB;
  typedef enum logic [1:0] {NBU_RX_IDLE, NBU_RX_BITS, NBU_RX_TAIL}
    nbu_rx_e;
endpackage : nbu_pkg

// [hdl/nbu_tick_if.sv]
`timescale 1ns/10ps
interface nbu_tick_if;
  logic        tick16;
  logic        fix_en;
  logic        fix64;
  logic        ext_en;
  logic        src_ext;
  logic [15:0] reload;
  modport gen  (output tick16, input fix_en, fix64, ext_en, src_ext, reload);
  modport core (input tick16, output fix_en, fix64, ext_en, src_ext, reload);
endinterface : nbu_tick_if

// [hdl/nbu_baud.sv]
`timescale 1ns/10ps
module nbu_baud
(
  input wire logic pclk,
  input wire logic presetn,
  nbu_tick_if.gen  t
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        tk_r;
  logic        tk_nxt;
  // -------------------------------------------------------------------
  // oversample tick: external enable, reload divider or fixed rate
  // -------------------------------------------------------------------
  always_comb
  begin
    cnt_nxt = cnt_r;
    tk_nxt  = 1'b0;
    if (t.fix_en)
    begin
      if (cnt_r[5:0] >= {10'h000, (t.fix64 ? nbu_pkg::FIX64_DIV
                                             : nbu_pkg::FIX32_DIV)})
      begin
        cnt_nxt = 16'h0000;
        tk_nxt  = 1'b1;
      end
      else
        cnt_nxt = cnt_r + 16'h0001;
    end
    else if (t.src_ext)
      tk_nxt = t.ext_en;
    else if (cnt_r >= t.reload)
    begin
      cnt_nxt = 16'h0000;
      tk_nxt  = 1'b1;
    end
    else
      cnt_nxt = cnt_r + 16'h0001;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 16'h0000;
      tk_r  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tk_r  <= tk_nxt;
    end
  end
  assign t.tick16 = tk_r;
endmodule : nbu_baud

// [hdl/nbu_top.sv]
`timescale 1ns/10ps
module nbu_top
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_ovf_en,
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin
);
  nbu_tick_if tif ();
  nbu_baud u_baud (.pclk(pclk), .presetn(presetn), .t(tif));
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  logic [7:0]  ctrl_r, ctrl_nxt;
  logic [15:0] baud_r, baud_nxt;
  logic [7:0]  rbuf_r, rbuf_nxt;
  logic [3:0]  txdiv_r, txdiv_nxt;
  logic        txreq_r, txreq_nxt;
  logic        send_r, send_nxt;
  logic        data_r, data_nxt;
  logic [3:0]  txph_r, txph_nxt;
  logic [8:0]  txsh_r, txsh_nxt;
  logic        txo_r, txo_nxt;
  nbu_pkg::nbu_rx_e rxst_r, rxst_nxt;
  logic [3:0]  rxdiv_r, rxdiv_nxt;
  logic [8:0]  rxsh_r, rxsh_nxt;
  logic [2:0]  smp_r, smp_nxt;
  logic [3:0]  rxcnt_r, rxcnt_nxt;
  logic        first_r, first_nxt;
  logic        rxprev_r, rxprev_nxt;
  logic        wr, rd_hit, tx_roll, vote;
  logic        set_txd, set_rxd;
  // -------------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------------
  function automatic logic is_reg(input logic [11:0] a);
    is_reg = (a == nbu_pkg::BUF_OFF) || (a == nbu_pkg::CTRL_OFF) ||
             (a == nbu_pkg::BAUD_OFF);
  endfunction : is_reg
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction : maj3
  assign pready  = 1'b1;
  assign wr      = psel & penable & pwrite;
  assign rd_hit  = is_reg(paddr);
  assign pslverr = psel & penable & ~rd_hit;
  assign tif.fix_en  = ctrl_r[nbu_pkg::C_FIX];
  assign tif.fix64   = ctrl_r[nbu_pkg::C_F64];
  assign tif.src_ext = ctrl_r[nbu_pkg::C_SRC];
  assign tif.ext_en  = timer_ovf_en;
  assign tif.reload  = baud_r;
  assign tx_roll = tif.tick16 && (txdiv_r == 4'hF);
  assign vote    = maj3(smp_r);
  assign serial_tx_pin = txo_r;
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (paddr == nbu_pkg::BUF_OFF)
      prdata = {24'h00_0000, rbuf_r};
    else if (paddr == nbu_pkg::CTRL_OFF)
      prdata = {24'h00_0000, ctrl_r};
    else if (paddr == nbu_pkg::BAUD_OFF)
      prdata = {16'h0000, baud_r};
  end
  // -------------------------------------------------------------------
  // transmit: send is the start bit, data gates the shifter output
  // -------------------------------------------------------------------
  always_comb
  begin
    txdiv_nxt = txdiv_r;
    txreq_nxt = txreq_r;
    send_nxt  = send_r;
    data_nxt  = data_r;
    txph_nxt  = txph_r;
    txsh_nxt  = txsh_r;
    set_txd   = 1'b0;
    if (tif.tick16)
      txdiv_nxt = txdiv_r + 4'h1;
    // a write while busy is dropped so a frame is never corrupted
    if (wr && paddr == nbu_pkg::BUF_OFF && !txreq_r && !send_r)
    begin
      txsh_nxt  = {ctrl_r[nbu_pkg::C_TX9], pwdata[7:0]};
      txreq_nxt = 1'b1;
    end
    else if (tx_roll && txreq_r)
    begin
      txreq_nxt = 1'b0;
      send_nxt  = 1'b1;
      txph_nxt  = 4'h0;
    end
    else if (tx_roll && send_r)
    begin
      txph_nxt = txph_r + 4'h1;
      if (txph_r == 4'h0)
        data_nxt = 1'b1;
      else if (txph_r == 4'h1)
        txsh_nxt = {1'b1, txsh_r[8:1]};
      else
        txsh_nxt = {1'b0, txsh_r[8:1]};
      // ninth at output with stop next: done after this shift
      if (txph_r == nbu_pkg::TX_BITS - 4'h2)
      begin
        send_nxt = 1'b0;
        data_nxt = 1'b0;
        set_txd  = 1'b1;
      end
    end
  end
  always_comb
  begin
    txo_nxt = 1'b1;
    if (send_r && !data_r)
      txo_nxt = 1'b0;
    else if (send_r)
      txo_nxt = txsh_r[0];
  end
  // -------------------------------------------------------------------
  // receive: 9-bit shifter, zeros then ones leave left, a shift count of nine marks the end
  // -------------------------------------------------------------------
  always_comb
  begin
    rxst_nxt   = rxst_r;
    rxdiv_nxt  = rxdiv_r;
    rxsh_nxt   = rxsh_r;
    smp_nxt    = smp_r;
    rxcnt_nxt  = rxcnt_r;
    first_nxt  = first_r;
    rxprev_nxt = rxprev_r;
    rbuf_nxt   = rbuf_r;
    set_rxd    = 1'b0;
    if (tif.tick16)
    begin
      rxprev_nxt = serial_rx_pin;
      rxdiv_nxt  = rxdiv_r + 4'h1;
      if (rxdiv_r >= nbu_pkg::SAMP_A && rxdiv_r <= nbu_pkg::SAMP_C)
        smp_nxt = {smp_r[1:0], serial_rx_pin};
      case (rxst_r)
        nbu_pkg::NBU_RX_IDLE:
          if (rxprev_r && !serial_rx_pin)
          begin
            rxdiv_nxt = 4'h0;
            rxsh_nxt  = nbu_pkg::RX_INIT;
            rxcnt_nxt = 4'h0;
            first_nxt = 1'b1;
            rxst_nxt  = nbu_pkg::NBU_RX_BITS;
          end
        nbu_pkg::NBU_RX_BITS:
          if (rxdiv_r == 4'hF)
          begin
            first_nxt = 1'b0;
            if (first_r && vote)
              rxst_nxt = nbu_pkg::NBU_RX_IDLE;
            else
            begin
              rxsh_nxt  = {rxsh_r[7:0], vote};
              rxcnt_nxt = rxcnt_r + 4'h1;
              // the load value leaves zeros at the top, so the start bit
              // is tracked by counting start plus eight data shifts
              if (rxcnt_r == nbu_pkg::TX_BITS - 4'h2 && !rxsh_r[8])
              begin
                // stop bit never reaches the shifter
                if (!ctrl_r[nbu_pkg::C_RXD] &&
                    (!ctrl_r[nbu_pkg::C_MPE] || vote))
                begin
                  // first data bit sits highest after the left shifts
                  rbuf_nxt = {rxsh_r[0], rxsh_r[1], rxsh_r[2], rxsh_r[3],
                              rxsh_r[4], rxsh_r[5], rxsh_r[6],
                              rxsh_r[7]};
                  set_rxd  = 1'b1;
                end
                rxst_nxt = nbu_pkg::NBU_RX_TAIL;
              end
            end
          end
        default:
          if (rxdiv_r == 4'hF)
            rxst_nxt = nbu_pkg::NBU_RX_IDLE;
      endcase
    end
  end
  // -------------------------------------------------------------------
  // registers; hardware set wins over software clear
  // -------------------------------------------------------------------
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    baud_nxt = baud_r;
    if (wr && paddr == nbu_pkg::CTRL_OFF)
      ctrl_nxt = pwdata[7:0];
    if (wr && paddr == nbu_pkg::BAUD_OFF)
      baud_nxt = pwdata[15:0];
    if (set_txd)
      ctrl_nxt[nbu_pkg::C_TXD] = 1'b1;
    if (set_rxd)
    begin
      ctrl_nxt[nbu_pkg::C_RXD] = 1'b1;
      ctrl_nxt[nbu_pkg::C_RX9] = vote;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r   <= nbu_pkg::CTRL_RST;
      baud_r   <= nbu_pkg::BAUD_RST;
      rbuf_r   <= 8'h00;
      txdiv_r  <= 4'h0;
      txreq_r  <= 1'b0;
      send_r   <= 1'b0;
      data_r   <= 1'b0;
      txph_r   <= 4'h0;
      txsh_r   <= 9'h000;
      txo_r    <= 1'b1;
      rxst_r   <= nbu_pkg::NBU_RX_IDLE;
      rxdiv_r  <= 4'h0;
      rxsh_r   <= 9'h1FF;
      smp_r    <= 3'h7;
      rxcnt_r  <= 4'h0;
      first_r  <= 1'b0;
      rxprev_r <= 1'b1;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      baud_r   <= baud_nxt;
      rbuf_r   <= rbuf_nxt;
      txdiv_r  <= txdiv_nxt;
      txreq_r  <= txreq_nxt;
      send_r   <= send_nxt;
      data_r   <= data_nxt;
      txph_r   <= txph_nxt;
      txsh_r   <= txsh_nxt;
      txo_r    <= txo_nxt;
      rxst_r   <= rxst_nxt;
      rxdiv_r  <= rxdiv_nxt;
      rxsh_r   <= rxsh_nxt;
      smp_r    <= smp_nxt;
      rxcnt_r  <= rxcnt_nxt;
      first_r  <= first_nxt;
      rxprev_r <= rxprev_nxt;
    end
  end
endmodule : nbu_top

// [tb/nbu_top_monitor.sv]
`timescale 1ns/10ps
module nbu_top_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_ovf_en,
  input wire logic        serial_rx_pin,
  input wire logic        serial_tx_pin
);
  // ---------------------------------------------------------------
  // port checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic bad_a = (paddr != nbu_pkg::BUF_OFF) &&
                     (paddr != nbu_pkg::CTRL_OFF) &&
                     (paddr != nbu_pkg::BAUD_OFF);
  property p_rdy; psel |-> pready; endproperty
  a_rdy: assert property (p_rdy)
    else $error("pready low");
  property p_err; psel && penable && bad_a |-> pslverr; endproperty
  a_err: assert property (p_err)
    else $error("no error on unmapped access");
  property p_ok; psel && penable && !bad_a |-> !pslverr; endproperty
  a_ok: assert property (p_ok)
    else $error("error on mapped access");
  property p_rdz;
    psel && !pwrite && bad_a |-> prdata == 32'h0000_0000;
  endproperty
  a_rdz: assert property (p_rdz)
    else $error("unmapped read not zero");
  property p_byte;
    psel && !pwrite && paddr == nbu_pkg::BUF_OFF |->
      prdata[31:8] == 24'h00_0000;
  endproperty
  a_byte: assert property (p_byte)
    else $error("buffer read wider than a byte");
  property p_rst; $rose(presetn) |-> serial_tx_pin; endproperty
  a_rst: assert property (p_rst)
    else $error("tx pin not idle after reset");
  // bit cells are at least sixteen ticks, so eight cycles is safe
  property p_fall; $fell(serial_tx_pin) |-> !serial_tx_pin [*8]; endproperty
  a_fall: assert property (p_fall)
    else $error("short low bit cell");
  property p_rise; $rose(serial_tx_pin) |-> serial_tx_pin [*8]; endproperty
  a_rise: assert property (p_rise)
    else $error("short high bit cell");
  c_wr: cover property (psel && penable && pwrite && paddr == 12'h000);
  c_tx: cover property ($fell(serial_tx_pin));
  c_err: cover property (pslverr);
endmodule : nbu_top_monitor
bind nbu_top nbu_top_monitor mon_u
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_ovf_en(timer_ovf_en),
  .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin)
);

// [tb/nbu_uart_node.sv]
`timescale 1ns/10ps
module nbu_uart_node
(
  input wire logic pclk,
  input wire logic line_in,
  output logic     line_out
);
  // ---------------------------------------------------------------
  // remote node, one pclk per tick at the default bit_len of 16
  // ---------------------------------------------------------------
  // pclk per bit cell; the bench sets it to match the selected rate
  int          bit_len = 16;
  logic [10:0] got;
  int          frames = 0;
  initial line_out = 1'b1;
  task automatic send(input logic [8:0] v, input logic stp, input logic glt);
    logic [10:0] f;
    f = {stp, v, 1'b0};
    if (glt)
    begin
      // too short to win the majority vote
      line_out <= 1'b0;
      repeat (4) @(posedge pclk);
      line_out <= 1'b1;
      repeat (28) @(posedge pclk);
    end
    for (int i = 0; i < 11; i++)
    begin
      line_out <= f[i];
      repeat (bit_len) @(posedge pclk);
    end
    line_out <= 1'b1;
    repeat (bit_len) @(posedge pclk);
  endtask : send
  always
  begin
    @(negedge line_in);
    repeat (bit_len / 2) @(posedge pclk);
    for (int i = 0; i < 11; i++)
    begin
      got[i] = line_in;
      if (i < 10)
        repeat (bit_len) @(posedge pclk);
    end
    frames++;
  end
endmodule : nbu_uart_node

// [tb/nbu_top_bench.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module nbu_top_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_line;
  logic        tx_line;
  logic [31:0] rd;
  logic        erd;
  logic        ovf = 1'b0;
  logic        ovf_on = 1'b0;
  logic [7:0]  cfg;
  int          bl;
  int          err_total = 0;
  int          checks = 0;
  int          el;
  always #5 pclk = ~pclk;
  // timer overflow source: one pulse every second cycle while enabled
  always @(posedge pclk) ovf <= ovf_on & ~ovf;
  nbu_top dut_u
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_ovf_en(ovf),
    .serial_rx_pin(rx_line), .serial_tx_pin(tx_line)
  );
  nbu_uart_node node_u (.pclk(pclk), .line_in(tx_line), .line_out(rx_line));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    erd = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_bit(input int b);
    el = 0;
    do
    begin
      apb(1'b0, nbu_pkg::CTRL_OFF, 32'h0000_0000);
      el += 3;
    end
    while (rd[b] !== 1'b1 && el < 800);
  endtask : wait_bit
  task automatic rx_case(input logic [8:0] c, input logic [8:0] v,
                         input logic stp, input logic glt,
                         input logic [9:0] ex);
    if (c[8])
      apb(1'b1, nbu_pkg::CTRL_OFF, {24'h00_0000, c[7:0]});
    node_u.send(v, stp, glt);
    repeat (20) @(posedge pclk);
    apb(1'b0, nbu_pkg::CTRL_OFF, 32'h0000_0000);
    `CHK({rd[nbu_pkg::C_RX9], rd[nbu_pkg::C_RXD]}, ex[9:8])
    apb(1'b0, nbu_pkg::BUF_OFF, 32'h0000_0000);
    `CHK(rd[7:0], ex[7:0])
  endtask : rx_case
  task automatic summarize();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, nbu_pkg::CTRL_OFF, 32'h0000_0000);
    `CHK(rd[7:0], nbu_pkg::CTRL_RST)
    apb(1'b0, nbu_pkg::BAUD_OFF, 32'h0000_0000);
    `CHK(rd[15:0], nbu_pkg::BAUD_RST)
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    `CHK({erd, rd}, {1'b1, 32'h0000_0000})
    $display("test regs done");
    for (int k = 0; k < 6; k++)
    begin
      // rates: reload 0 twice, timer pulses, fixed /32, /64, reload 1
      bl = (k < 2) ? 16 : ((k == 4) ? 64 : 32);
      node_u.bit_len = bl;
      ovf_on <= (k == 2);
      cfg = 8'h00;
      cfg[nbu_pkg::C_TX9] = k[0];
      cfg[nbu_pkg::C_SRC] = (k == 2);
      cfg[nbu_pkg::C_FIX] = (k == 3 || k == 4);
      cfg[nbu_pkg::C_F64] = (k == 4);
      apb(1'b1, nbu_pkg::BAUD_OFF, {31'h0000_0000, k == 5});
      apb(1'b1, nbu_pkg::CTRL_OFF, {24'h00_0000, cfg});
      apb(1'b1, nbu_pkg::BUF_OFF, 32'h0000_00A5);
      // second write lands while busy and must be dropped
      apb(1'b1, nbu_pkg::BUF_OFF, 32'h0000_003C);
      wait_bit(nbu_pkg::C_TXD);
      `CHK(el >= 10 * bl - 10 && el <= 11 * bl + 4, 1'b1)
      repeat (2 * bl) @(posedge pclk);
      `CHK(node_u.got, {1'b1, k[0], 8'hA5, 1'b0})
      `CHK(tx_line, 1'b1)
    end
    ovf_on <= 1'b0;
    node_u.bit_len = 16;
    apb(1'b0, nbu_pkg::BAUD_OFF, 32'h0000_0000);
    `CHK(rd[15:0], 16'h0001)
    apb(1'b1, nbu_pkg::BAUD_OFF, 32'h0000_0000);
    $display("test tx done");
    rx_case(9'h100, 9'h15A, 1'b1, 1'b0, 10'h35A);
    rx_case(9'h000, 9'h011, 1'b1, 1'b0, 10'h35A);
    rx_case(9'h112, 9'h022, 1'b1, 1'b0, 10'h25A);
    rx_case(9'h000, 9'h133, 1'b0, 1'b1, 10'h333);
    rx_case(9'h100, 9'h044, 1'b1, 1'b0, 10'h144);
    `CHK(node_u.frames, 6)
    $display("test rx done");
    summarize();
  end
  initial
  begin
    #60000;
    err_total++;
    summarize();
  end
endmodule : nbu_top_bench
